// ---- verilog/gpio_port.sv ----
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
// Contract
// - Five pins, index 0 to 4; indexes 5 and up select nothing.
// - Value 0 is low, 1 to 99 is PWM percent, 100 high, above invalid.
// - Intermediate duty cycles repeat at 100 Hz.
// - Every pin is sampled at about 32 Hz regardless of host queries.
// - Rising and falling flags latch between queries; a query clears them.
// - Status byte: bit 0 level, bit 1 falling, bit 2 rising, rest zero.
// - Reported level is the real sampled pin, not the commanded value.
// - Edges come only from samples; pulses between samples are unseen.
// - Drive modes 000, 001, 010, 011 as fast strong, pull and high-Z.
// - Drive modes 100, 101, 111 are slow edges; 110 is reserved.
// - Config bit 3 picks user or default function; drive mode applies to both.
// - Two payload bytes set value only; three also set function and mode.
// - Set command 0x22 applies settings and answers type 0x62, empty.
// - Read command 0x23 returns index, status, requested level, config.
// - Returned level is the commanded value 0 to 100.
// - Reserved upper config bits read back as zero.
// - Periodic sampling makes input reading immune to switch bounce.
// - Pin configuration is saved as and restored from the boot state.
// - Defaults keep power-control and one-wire functions working.
module gpio_port import gpio_pkg::*; #(
  parameter int SAMPLE_DIV = SAMPLE_CYC,
  parameter int PWM_DIV = PWM_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_pu,
  output logic [NUM_PINS-1:0] pin_pd,
  output logic [NUM_PINS-1:0] pin_slow,
  output logic [NUM_PINS-1:0] pin_owner,
  input wire logic [NUM_PINS-1:0] dflt_level,
  input wire logic boot_load
);
  localparam int SW = $clog2(SAMPLE_DIV + 1);
  localparam int PW = $clog2(PWM_DIV + 1);

  // Drive decode from mode and the level wanted at the pin.
  function automatic pin_drv_s drive_f(input logic [2:0] m, input logic h);
    pin_drv_s d;
    d = '0;
    case (m)
      3'h0: begin
        d.oe = h;
        d.o = h;
        d.pd = ~h;
      end
      3'h1: begin
        d.oe = 1'b1;
        d.o = h;
      end
      3'h3: begin
        d.oe = ~h;
        d.pu = h;
      end
      3'h4: begin
        d.oe = h;
        d.o = h;
        d.slow = h;
      end
      3'h5: begin
        d.oe = 1'b1;
        d.o = h;
        d.slow = 1'b1;
      end
      3'h7: begin
        d.oe = ~h;
        d.slow = ~h;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  logic wait_r;
  logic [31:0] rdata_r;
  logic [23:0] arg_r;
  logic [9:0] cmd_r;
  logic [15:0] resp_r;
  logic [31:0] rsp_data_r;
  logic [SW-1:0] samp_cnt_r;
  logic [PW-1:0] step_cnt_r;
  logic [6:0] pwm_cnt_r;
  logic samp_tick_r;
  logic [NUM_PINS-1:0] samp_r;
  logic [NUM_PINS-1:0] rise_r;
  logic [NUM_PINS-1:0] fall_r;
  logic [6:0] lvl_r [NUM_PINS];
  pin_cfg_s cfg_r [NUM_PINS];
  logic [6:0] boot_lvl_r [NUM_PINS];
  pin_cfg_s boot_cfg_r [NUM_PINS];
  logic primed_r;
  // Flat copy of every pin's settings, so the checks can compare them in one go.
  logic [NUM_PINS*11-1:0] set_flat_w;

  // Bus decode. A write lands only at the edge where waitrequest is seen low.
  wire bus_req = avs_read | avs_write;
  wire wr_go = avs_write & ~wait_r;
  wire wr_arg = wr_go & (avs_address == OFS_ARG);
  wire cmd_go = wr_go & (avs_address == OFS_CMD);
  wire wr_boot = wr_go & (avs_address == OFS_BOOT);
  wire save_go = wr_boot & avs_writedata[BOOT_SAVE];
  wire load_go = (wr_boot & avs_writedata[BOOT_LOAD]) | boot_load;

  // Command fields.
  wire [7:0] cmd_code = avs_writedata[7:0];
  wire [1:0] cmd_len = avs_writedata[9:8];
  wire [7:0] arg_idx = arg_r[7:0];
  wire [7:0] arg_val = arg_r[15:8];
  wire [7:0] arg_cfg = arg_r[23:16];
  wire idx_ok = arg_idx < 8'(NUM_PINS);
  wire val_ok = arg_val <= VAL_HIGH;
  wire cfg_ok = arg_cfg <= CFG_MAX;
  wire len_cfg = cmd_len == LEN_SET_CFG;
  wire set_len_ok = (cmd_len == LEN_SET_VAL) | len_cfg;
  wire set_ok = (cmd_code == CMD_SET) & set_len_ok & idx_ok & val_ok & (~len_cfg | cfg_ok);
  wire rd_ok = (cmd_code == CMD_READ) & (cmd_len == LEN_READ) & idx_ok;
  wire set_go = cmd_go & set_ok;
  wire rd_go = cmd_go & rd_ok;
  wire [2:0] sel = idx_ok ? arg_idx[2:0] : 3'h0;

  // Per-pin status and readback.
  logic [7:0] stat_w [NUM_PINS];
  logic [NUM_PINS-1:0] pwm_hi_w;
  pin_drv_s drv_w [NUM_PINS];

  // Answer packet: ack type or error type with the code folded in.
  wire [7:0] ack_type = cmd_code | RSP_ACK;
  wire [7:0] err_type = RSP_ERR | {2'h0, cmd_code[5:0]};
  wire [7:0] rsp_type = (set_ok | rd_ok) ? ack_type : err_type;
  wire [7:0] rsp_len = rd_ok ? LEN_READ_RSP : 8'h00;
  wire [31:0] rsp_data = {4'h0, cfg_r[sel], 1'b0, lvl_r[sel], stat_w[sel], arg_idx};

  // Read mux; unmapped offsets read as zero.
  wire [31:0] rd_mux =
    (avs_address == OFS_ARG) ? {8'h00, arg_r} :
    (avs_address == OFS_CMD) ? {22'h0, cmd_r} :
    (avs_address == OFS_RESP) ? {16'h0, resp_r} :
    (avs_address == OFS_RDATA) ? rsp_data_r :
    (avs_address == OFS_PINS) ? {{(32-NUM_PINS){1'b0}}, samp_r} : 32'h0;

  // One wait cycle per access; readdata is loaded as waitrequest drops.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= ~(bus_req & wait_r);
      if (avs_read & wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Command argument and answer registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arg_r <= 24'h0;
      cmd_r <= 10'h0;
      resp_r <= 16'h0;
      rsp_data_r <= 32'h0;
    end else begin
      if (wr_arg) begin
        arg_r <= avs_writedata[23:0];
      end
      if (cmd_go) begin
        cmd_r <= avs_writedata[9:0];
        resp_r <= {rsp_len, rsp_type};
      end
      if (rd_go) begin
        rsp_data_r <= rsp_data;
      end
    end
  end

  // Slow enables: 32 Hz sample tick and the PWM step tick.
  // The first sample after reset only primes the edge detector: with no earlier sample to
  // compare against, a pin that idles high would otherwise report a false rising edge.
  wire samp_wrap = samp_cnt_r == SW'(SAMPLE_DIV - 1);
  wire step_wrap = step_cnt_r == PW'(PWM_DIV - 1);
  wire pwm_wrap = pwm_cnt_r == 7'(PWM_STEPS - 1);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      samp_cnt_r <= '0;
      step_cnt_r <= '0;
      pwm_cnt_r <= 7'h0;
      samp_tick_r <= 1'b0;
      primed_r <= 1'b0;
    end else begin
      samp_cnt_r <= samp_wrap ? '0 : samp_cnt_r + SW'(1);
      samp_tick_r <= samp_wrap;
      primed_r <= primed_r | samp_tick_r;
      step_cnt_r <= step_wrap ? '0 : step_cnt_r + PW'(1);
      if (step_wrap) begin
        pwm_cnt_r <= pwm_wrap ? 7'h0 : pwm_cnt_r + 7'h1;
      end
    end
  end

  // Per-pin settings, sampling, edge flags and drive.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    localparam pin_cfg_s CFG0 = pin_cfg_s'(DFLT_CFG[i*4 +: 4]);
    wire set_me = set_go & (arg_idx == 8'(i));
    wire rd_me = rd_go & (arg_idx == 8'(i));
    wire rise_ev = samp_tick_r & primed_r & ~samp_r[i] & pin_i[i];
    wire fall_ev = samp_tick_r & primed_r & samp_r[i] & ~pin_i[i];
    wire want_hi = cfg_r[i].owner ? pwm_hi_w[i] : dflt_level[i];

    // Duty 0 never matches, 100 always matches the 0..99 counter.
    assign pwm_hi_w[i] = {1'b0, pwm_cnt_r} < {1'b0, lvl_r[i]};
    assign drv_w[i] = drive_f(cfg_r[i].mode, want_hi);
    assign stat_w[i] = {5'h0, rise_r[i], fall_r[i], samp_r[i]};
    assign set_flat_w[i*11 +: 11] = {cfg_r[i], lvl_r[i]};

    // Settings; factory values keep the default functions alive.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        lvl_r[i] <= DFLT_LVL;
        cfg_r[i] <= CFG0;
        boot_lvl_r[i] <= DFLT_LVL;
        boot_cfg_r[i] <= CFG0;
      end else begin
        if (save_go) begin
          boot_lvl_r[i] <= lvl_r[i];
          boot_cfg_r[i] <= cfg_r[i];
        end
        if (load_go) begin
          lvl_r[i] <= boot_lvl_r[i];
          cfg_r[i] <= boot_cfg_r[i];
        end else if (set_me) begin
          lvl_r[i] <= arg_val[6:0];
          if (len_cfg) begin
            cfg_r[i] <= pin_cfg_s'(arg_cfg[3:0]);
          end
        end
      end
    end

    // Sampled level and sticky flags; a sample edge beats a clearing query.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        samp_r[i] <= 1'b0;
        rise_r[i] <= 1'b0;
        fall_r[i] <= 1'b0;
      end else begin
        if (samp_tick_r) begin
          samp_r[i] <= pin_i[i];
        end
        rise_r[i] <= rise_ev | (rise_r[i] & ~rd_me);
        fall_r[i] <= fall_ev | (fall_r[i] & ~rd_me);
      end
    end

    // Registered pad controls.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        pin_o[i] <= 1'b0;
        pin_oe[i] <= 1'b0;
        pin_pu[i] <= 1'b0;
        pin_pd[i] <= 1'b0;
        pin_slow[i] <= 1'b0;
        pin_owner[i] <= 1'b0;
      end else begin
        pin_o[i] <= drv_w[i].o;
        pin_oe[i] <= drv_w[i].oe;
        pin_pu[i] <= drv_w[i].pu;
        pin_pd[i] <= drv_w[i].pd;
        pin_slow[i] <= drv_w[i].slow;
        pin_owner[i] <= cfg_r[i].owner;
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_IDX_RESERVED: assert property (
    cmd_go && !load_go && cmd_code == CMD_SET && arg_idx >= 8'(NUM_PINS)
    |=> $stable(set_flat_w))
    else $error("Reserved index changed a pin.");

  // Any refused value or reserved config bits must leave every pin untouched.
  AST_BAD_VALUE: assert property (
    cmd_go && !load_go && (arg_val > VAL_HIGH || (len_cfg && arg_cfg > CFG_MAX))
    |=> $stable(set_flat_w))
    else $error("Refused settings were stored.");

  AST_PWM_WRAP: assert property (
    step_wrap && pwm_wrap |=> pwm_cnt_r == 7'h0)
    else $error("PWM counter did not wrap after 100 steps.");

  AST_DUTY_ENDS: assert property (
    (lvl_r[0] == 7'h0 |-> !pwm_hi_w[0]) and (lvl_r[0] == 7'h64 |-> pwm_hi_w[0]))
    else $error("Duty 0 or 100 did not give a constant level.");

  AST_SAMPLE: assert property (
    samp_tick_r |=> samp_r == $past(pin_i))
    else $error("Sample tick did not capture the pins.");

  AST_ONLY_TICK: assert property (
    !samp_tick_r |=> $stable(samp_r) && !(rise_r[0] && !$past(rise_r[0])))
    else $error("Level or edge changed without a sample tick.");

  // Pin 0 stands in for every pin in the per-pin flag checks.
  wire rd_me0 = rd_go & (arg_idx == 8'h0);

  AST_RISE: assert property (
    samp_tick_r && primed_r && !samp_r[0] && pin_i[0]
    |=> rise_r[0] ##1 rise_r[0] || $past(rd_me0))
    else $error("Rising edge was not latched.");

  AST_ACK: assert property (
    cmd_go && set_ok |=> resp_r == {8'h00, 8'h62})
    else $error("Set command not acknowledged with type 0x62.");

  AST_RDATA: assert property (
    rd_go |=> rsp_data_r[7:0] == $past(arg_idx) && rsp_data_r[15:11] == 5'h0
      && rsp_data_r[31:28] == 4'h0 && resp_r == {8'h04, 8'h63})
    else $error("Read answer layout is wrong.");

  AST_QUERY_CLEAR: assert property (
    rd_me0 && !(samp_tick_r && samp_r[0] != pin_i[0]) |=> !rise_r[0] && !fall_r[0])
    else $error("Query did not clear the edge flags.");

  AST_WAIT: assert property (
    bus_req && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer is not one cycle after the request.");
endmodule
`default_nettype wire

// ---- verilog/gpio_pkg.sv ----
`default_nettype none
package gpio_pkg;
  // Clock and derived timing.
  localparam int CLK_NS = 8;
  localparam int SAMPLE_US = 31250;
  localparam int SAMPLE_CYC = SAMPLE_US * 1000 / CLK_NS;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int PWM_STEP_CYC = 1000000000 / (PWM_HZ * PWM_STEPS) / CLK_NS;
  localparam int NUM_PINS = 5;

  // Register byte offsets.
  localparam logic [4:0] OFS_ARG = 5'h00;
  localparam logic [4:0] OFS_CMD = 5'h04;
  localparam logic [4:0] OFS_RESP = 5'h08;
  localparam logic [4:0] OFS_RDATA = 5'h0c;
  localparam logic [4:0] OFS_BOOT = 5'h10;
  localparam logic [4:0] OFS_PINS = 5'h14;

  // Command packet codes and lengths.
  localparam logic [7:0] CMD_SET = 8'h22;
  localparam logic [7:0] CMD_READ = 8'h23;
  localparam logic [7:0] RSP_ACK = 8'h40;
  localparam logic [7:0] RSP_ERR = 8'hc0;
  localparam logic [1:0] LEN_SET_VAL = 2'h2;
  localparam logic [1:0] LEN_SET_CFG = 2'h3;
  localparam logic [1:0] LEN_READ = 2'h1;
  localparam logic [7:0] LEN_READ_RSP = 8'h04;
  localparam logic [7:0] VAL_HIGH = 8'h64;
  localparam logic [7:0] CFG_MAX = 8'h0f;

  // Status byte fields.
  localparam int ST_LVL = 0;
  localparam int ST_FALL = 1;
  localparam int ST_RISE = 2;

  // Boot control bits.
  localparam int BOOT_SAVE = 0;
  localparam int BOOT_LOAD = 1;

  // Factory defaults: pin 1 pull-up sense, others high impedance, all default function.
  localparam logic [6:0] DFLT_LVL = 7'h00;
  localparam logic [NUM_PINS*4-1:0] DFLT_CFG = 20'h22232;

  typedef struct packed {
    logic owner;
    logic [2:0] mode;
  } pin_cfg_s;

  typedef struct packed {
    logic oe;
    logic o;
    logic pu;
    logic pd;
    logic slow;
  } pin_drv_s;
endpackage
`default_nettype wire

// ---- bench/pad_model.sv ----
`default_nettype none
// Pad and outside load: a design driver wins, then an outside source, then the weak pulls.
module pad_model (
  input wire logic mclk,
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pin_pu,
  input wire logic [4:0] pin_pd,
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  output logic [4:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_r = 1'b0;
  // A floating pad toggles every cycle, so no test can lean on its level.
  always @(posedge mclk) begin
    float_r <= ~float_r;
  end
  // An outside source beats a pull, which is why the sampled level may differ from the request.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pin_pu | (~pin_pd & {5{float_r}})));
endmodule
`default_nettype wire

// ---- bench/packet_controlled_gpio_port_bench.sv ----
`default_nettype none
module packet_controlled_gpio_port_bench import gpio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SDIV = 20;
  localparam int PDIV = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] pin_i, pin_o, pin_oe, pin_pu, pin_pd, pin_slow, pin_owner;
  logic [4:0] dflt_level = 5'h1f;
  logic boot_load = 1'b0;
  logic [4:0] ext_en = 5'h1f;
  logic [4:0] ext_val = 5'h00;
  logic [31:0] rd;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int hi;
  logic [4:0] drv_seen;
  logic [7:0] duty [5] = '{8'h00, 8'h01, 8'h19, 8'h63, 8'h64};

  always #4 mclk = ~mclk;

  gpio_port #(.SAMPLE_DIV(SDIV), .PWM_DIV(PDIV)) i_dut (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_pu(pin_pu), .pin_pd(pin_pd), .pin_slow(pin_slow), .pin_owner(pin_owner),
    .dflt_level(dflt_level), .boot_load(boot_load));

  pad_model i_pad (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .pin_pd(pin_pd), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

  // Compares one value and counts it.
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task done(input string s);
    $display("test %s finished, mismatches so far %0d", s, err_total);
  endtask

  // One bus access; the request stands until waitrequest is seen low at an edge.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Fires a command packet and checks the answer header.
  task cmd(input logic [7:0] code, input logic [1:0] len, input logic [7:0] idx,
      input logic [7:0] val, input logic [7:0] cfg, input logic ok);
    bus(1'b1, OFS_ARG, {8'h00, cfg, val, idx});
    bus(1'b1, OFS_CMD, {22'h0, len, code});
    bus(1'b0, OFS_RESP, 32'h0);
    if (ok)
      chk("resp", {16'h0, (code == CMD_READ) ? LEN_READ_RSP : 8'h00, code | 8'h40}, rd);
    else
      chk("resp", {24'h0, 8'hc0 | {2'b00, code[5:0]}}, rd);
  endtask

  task rdpin(input logic [7:0] idx, input logic [7:0] st, input logic [7:0] lvl,
      input logic [7:0] cfg);
    cmd(CMD_READ, LEN_READ, idx, 8'h00, 8'h00, 1'b1);
    bus(1'b0, OFS_RDATA, 32'h0);
    chk("rdata", {cfg, lvl, st, idx}, rd);
  endtask

  // Expected {oe, o, pu, pd, slow} of a user pin for drive mode m and level h.
  function automatic logic [4:0] exp_drv(input logic [2:0] m, input logic h);
    case ({m, h})
      4'b0001, 4'b0011: return 5'b11000;
      4'b0000: return 5'b00010;
      4'b0010, 4'b0110: return 5'b10000;
      4'b0111: return 5'b00100;
      4'b1001, 4'b1011: return 5'b11001;
      4'b1010, 4'b1110: return 5'b10001;
      default: return 5'b00000;
    endcase
  endfunction

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A hang is cut off well beyond the few thousand cycles the tests need.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("pads", {pin_oe, pin_pu, pin_pd, pin_owner}, {5'h00, 5'h02, 5'h00, 5'h00});
    for (int i = 0; i < 5; i++) rdpin(i[7:0], 8'h00, 8'h00, (i == 1) ? 8'h03 : 8'h02);
    done("defaults");
    cmd(CMD_SET, LEN_SET_CFG, 8'h05, 8'h00, 8'h00, 1'b0);
    cmd(CMD_SET, LEN_SET_CFG, 8'h02, 8'h65, 8'h09, 1'b0);
    cmd(CMD_SET, LEN_SET_CFG, 8'h02, 8'h32, 8'h10, 1'b0);
    cmd(CMD_READ, LEN_READ, 8'h05, 8'h00, 8'h00, 1'b0);
    rdpin(8'h02, 8'h00, 8'h00, 8'h02);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, rd);
    done("refusals");
    cmd(CMD_SET, LEN_SET_CFG, 8'h02, 8'h64, 8'h0a, 1'b1);
    cmd(CMD_SET, LEN_SET_VAL, 8'h02, 8'h32, 8'h03, 1'b1);
    rdpin(8'h02, 8'h00, 8'h32, 8'h0a);
    cmd(CMD_SET, LEN_SET_CFG, 8'h02, 8'h64, 8'h0b, 1'b1);
    repeat (2 * SDIV + 4) @(posedge mclk);
    rdpin(8'h02, 8'h00, 8'h64, 8'h0b);
    done("payload length");
    // Every drive mode at both constant levels, then the pin handed back.
    for (int m = 0; m < 8; m++) begin
      for (int h = 0; h < 2; h++) begin
        cmd(CMD_SET, LEN_SET_CFG, 8'h04, h ? 8'h64 : 8'h00, {5'h01, m[2:0]}, 1'b1);
        repeat (3) @(posedge mclk);
        drv_seen = {pin_oe[4], pin_o[4] & pin_oe[4], pin_pu[4], pin_pd[4],
          pin_slow[4] & pin_oe[4]};
        chk("drive", exp_drv(m[2:0], h[0]), drv_seen);
        chk("owner", 32'h1, pin_owner[4]);
      end
    end
    cmd(CMD_SET, LEN_SET_CFG, 8'h04, 8'h00, 8'h01, 1'b1);
    repeat (3) @(posedge mclk);
    chk("dflt drive", 32'h3, {pin_owner[4], pin_oe[4], pin_o[4]});
    done("drive modes");
    // High time over one full period equals the duty in steps; 0 and 100 stay flat.
    for (int k = 0; k < 5; k++) begin
      cmd(CMD_SET, LEN_SET_CFG, 8'h00, duty[k], 8'h09, 1'b1);
      repeat (8) @(posedge mclk);
      hi = 0;
      repeat (100 * PDIV) begin
        @(posedge mclk);
        hi += pin_o[0];
      end
      chk("pwm high", duty[k] * PDIV, hi);
    end
    cmd(CMD_SET, LEN_SET_CFG, 8'h00, 8'h00, 8'h0a, 1'b1);
    done("pwm");
    cmd(CMD_SET, LEN_SET_CFG, 8'h03, 8'h00, 8'h0a, 1'b1);
    repeat (2 * SDIV + 4) @(posedge mclk);
    rdpin(8'h03, 8'h00, 8'h00, 8'h0a);
    ext_val[3] <= 1'b1;
    repeat (2 * SDIV + 4) @(posedge mclk);
    rdpin(8'h03, 8'h05, 8'h00, 8'h0a);
    rdpin(8'h03, 8'h01, 8'h00, 8'h0a);
    ext_val[3] <= 1'b0;
    repeat (2 * SDIV + 4) @(posedge mclk);
    ext_val[3] <= 1'b1;
    repeat (2 * SDIV + 4) @(posedge mclk);
    rdpin(8'h03, 8'h07, 8'h00, 8'h0a);
    bus(1'b0, OFS_PINS, 32'h0);
    chk("pins", 32'h18, rd);
    done("edges");
    cmd(CMD_SET, LEN_SET_CFG, 8'h03, 8'h00, 8'h0b, 1'b1);
    bus(1'b1, OFS_BOOT, 32'h1);
    cmd(CMD_SET, LEN_SET_CFG, 8'h03, 8'h00, 8'h09, 1'b1);
    bus(1'b1, OFS_BOOT, 32'h2);
    repeat (2 * SDIV + 4) @(posedge mclk);
    rdpin(8'h03, 8'h02, 8'h00, 8'h0b);
    cmd(CMD_SET, LEN_SET_CFG, 8'h03, 8'h00, 8'h09, 1'b1);
    boot_load <= 1'b1;
    @(posedge mclk);
    boot_load <= 1'b0;
    repeat (3) @(posedge mclk);
    rdpin(8'h03, 8'h00, 8'h00, 8'h0b);
    done("boot state");
    report_and_stop();
  end
endmodule
`default_nettype wire
